// ### hw/rwi_reset_wake_init.sv
`timescale 1ns/1ns
`include "rwi_defines.svh"
module rwi_reset_wake_init
  import rwi_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // reset sources
  input wire logic POR_EVENT,
  input wire logic GRP_RESET_EVENT,
  // sleep and wake
  input wire logic SLEEP_REQ,
  input wire logic WAKE_WDT,
  input wire logic WAKE_IRQ,
  input wire logic [7:0] WAKE_PERIPH_FLAGS,
  input wire logic WAKE_IRQ_HIGH,
  // port pins seen from outside
  input wire logic [7:0] PORT_PIN_IN,
  output logic [7:0] PORT_LATCH_OUT,
  output logic [7:0] PORT_DIR_OUT,
  // status
  output logic [`RWI_PC_W-1:0] PC_OUT,
  output logic ASLEEP,
  output logic IRQ
);
  rwi_state_t state_ff, nxt_state;
  logic [`RWI_PC_W-1:0] pc_ff, tos_ff;
  logic [`RWI_SP_W-1:0] sp_ff;
  logic [7:0] intcon_ff, intcon2_ff, intcon3_ff, pir1_ff, pir2_ff;
  logic [7:0] latch_ff, dir_ff;
  logic [2:0] cfg_ff;
  logic [`RWI_EV_W-1:0] status_ff, mask_ff, ev;
  logic swrst_ff;
  logic wr, rd, grp, wake_irq, vec;
  logic [7:0] pins_g, latch_g, dir_g;
  logic [31:0] nxt_rdata;

  // apb strobes; zero wait states
  assign wr = PSEL & PENABLE & PWRITE;
  assign rd = PSEL & ~PWRITE & ~PENABLE;
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;
  assign grp = GRP_RESET_EVENT | swrst_ff;
  // wake by interrupt only honoured while asleep
  assign wake_irq = (state_ff == RWI_ST_SLEEP) & WAKE_IRQ & ~POR_EVENT & ~grp;
  // vector only with a global enable
  assign vec = wake_irq & (intcon_ff[`RWI_HIGH_PRIORITY_GLOBAL_ENABLE_BIT] | intcon_ff[`RWI_LOW_PRIORITY_GLOBAL_ENABLE_BIT]);

  // address match helper
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  // sleep state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      RWI_ST_RUN: begin
        if (SLEEP_REQ) begin
          nxt_state = RWI_ST_SLEEP;
        end
      end
      RWI_ST_SLEEP: begin
        if (WAKE_IRQ | WAKE_WDT) begin
          nxt_state = RWI_ST_WAKE;
        end
      end
      RWI_ST_WAKE: nxt_state = RWI_ST_RUN;
      default: nxt_state = RWI_ST_RUN;
    endcase
    if (POR_EVENT | grp) begin
      nxt_state = RWI_ST_RUN;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_ff <= RWI_ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end
  assign ASLEEP = (state_ff == RWI_ST_SLEEP);

  // software reset request is one-shot
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      swrst_ff <= 1'b0;
    end else begin
      swrst_ff <= wr & hit(PADDR, `RWI_OFF_CTRL) & PWDATA[`RWI_CTRL_SWRST];
    end
  end

  // program counter and stack
  always_ff @(posedge CORE_CLK) begin
    if (RST | POR_EVENT) begin
      pc_ff <= '0;
      tos_ff <= '0;
      sp_ff <= '0;
    end else if (grp) begin
      pc_ff <= '0;
      tos_ff <= '0;
    end else if (vec) begin
      // save pc to top of stack
      tos_ff <= pc_ff;
      sp_ff <= sp_ff + `RWI_SP_W'(1);
      pc_ff <= WAKE_IRQ_HIGH ? `RWI_VEC_HIGH : `RWI_VEC_LOW;
    end else if ((state_ff == RWI_ST_SLEEP) & (WAKE_IRQ | WAKE_WDT)) begin
      // wake without vectoring resumes at the next instruction
      pc_ff <= pc_ff + `RWI_PC_STEP;
    end else if (wr & hit(PADDR, `RWI_OFF_PC)) begin
      pc_ff <= PWDATA[`RWI_PC_W-1:0];
    end
  end
  assign PC_OUT = pc_ff;

  // interrupt control and flag registers
  always_ff @(posedge CORE_CLK) begin
    if (RST | POR_EVENT | grp) begin
      intcon_ff <= `RWI_INTCON_RST;
      intcon2_ff <= `RWI_INTCON2_RST;
      intcon3_ff <= `RWI_INTCON3_RST;
      pir1_ff <= 8'h00;
      pir2_ff <= 8'h00;
    end else begin
      if (wr & hit(PADDR, `RWI_OFF_INT_CTRL)) begin
        intcon_ff <= PWDATA[7:0];
        intcon2_ff <= PWDATA[15:8] & `RWI_INTCON2_IMPL;
        intcon3_ff <= PWDATA[23:16] & `RWI_INTCON3_IMPL;
      end
      if (wr & hit(PADDR, `RWI_OFF_PERIPH_FLAG)) begin
        pir1_ff <= PWDATA[7:0] & `RWI_PIR1_IMPL;
        pir2_ff <= PWDATA[15:8] & `RWI_PIR2_IMPL;
      end
      if (wake_irq) begin
        pir1_ff <= (pir1_ff | WAKE_PERIPH_FLAGS) & `RWI_PIR1_IMPL;
      end
    end
  end

  // port latch and direction
  always_ff @(posedge CORE_CLK) begin
    if (RST | POR_EVENT | grp) begin
      latch_ff <= 8'h00;
      dir_ff <= 8'hFF;
    end else begin
      if (wr & hit(PADDR, `RWI_OFF_PORT_LATCH)) begin
        latch_ff <= PWDATA[7:0];
      end
      if (wr & hit(PADDR, `RWI_OFF_PORT_DIR)) begin
        dir_ff <= PWDATA[7:0];
      end
    end
  end

  // config: bit 0 variant has bit 6, bits 2:1 oscillator mode
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cfg_ff <= 3'h0;
    end else if (wr & hit(PADDR, `RWI_OFF_CFG)) begin
      cfg_ff <= PWDATA[2:0];
    end
  end

  rwi_port_gate u_gate (
    .bit6_present(cfg_ff[0]),
    .osc_mode(rwi_osc_mode_t'(cfg_ff[2:1])),
    .raw_pins(PORT_PIN_IN),
    .raw_latch(latch_ff),
    .raw_dir(dir_ff),
    .first_port_pins(pins_g),
    .first_port_latch(latch_g),
    .first_port_direction(dir_g)
  );
  // pins see the gated views, so a disabled bit 6 never leaves the block
  assign PORT_LATCH_OUT = latch_g;
  assign PORT_DIR_OUT = dir_g;

  // event status, write one to clear, set wins
  always_comb begin
    ev = '0;
    ev[`RWI_EV_POR] = POR_EVENT;
    ev[`RWI_EV_GRP] = grp;
    ev[`RWI_EV_WAKE] = wake_irq | ((state_ff == RWI_ST_SLEEP) & WAKE_WDT);
    ev[`RWI_EV_VEC] = vec;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      status_ff <= '0;
      mask_ff <= '0;
    end else begin
      if (wr & hit(PADDR, `RWI_OFF_MASK)) begin
        mask_ff <= PWDATA[`RWI_EV_W-1:0];
      end
      if (wr & hit(PADDR, `RWI_OFF_STATUS)) begin
        status_ff <= (status_ff & ~PWDATA[`RWI_EV_W-1:0]) | ev;
      end else begin
        status_ff <= status_ff | ev;
      end
    end
  end
  assign IRQ = |(status_ff & mask_ff);

  // read mux; unmapped reads zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (PADDR)
      `RWI_OFF_STATUS: nxt_rdata = {28'h0, status_ff};
      `RWI_OFF_MASK: nxt_rdata = {28'h0, mask_ff};
      `RWI_OFF_PC: nxt_rdata = {11'h0, pc_ff};
      `RWI_OFF_STACK_TOP: nxt_rdata = {11'h0, tos_ff};
      `RWI_OFF_STACK_PTR: nxt_rdata = {27'h0, sp_ff};
      `RWI_OFF_INT_CTRL: nxt_rdata = {8'h0, intcon3_ff, intcon2_ff, intcon_ff};
      `RWI_OFF_PERIPH_FLAG: nxt_rdata = {16'h0, pir2_ff, pir1_ff};
      `RWI_OFF_PORT_PINS: nxt_rdata = {24'h0, pins_g};
      `RWI_OFF_PORT_LATCH: nxt_rdata = {24'h0, latch_g};
      `RWI_OFF_PORT_DIR: nxt_rdata = {24'h0, dir_g};
      `RWI_OFF_CFG: nxt_rdata = {29'h0, cfg_ff};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // read data registered in setup, valid in access phase
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd) begin
      PRDATA <= nxt_rdata;
    end
  end
endmodule // rwi_reset_wake_init

// ### hw/rwi_defines.svh
`ifndef RWI_DEFINES_SVH
`define RWI_DEFINES_SVH
// apb byte offsets
`define RWI_OFF_CTRL 12'h000
`define RWI_OFF_STATUS 12'h004
`define RWI_OFF_MASK 12'h008
`define RWI_OFF_PC 12'h00C
`define RWI_OFF_STACK_TOP 12'h010
`define RWI_OFF_STACK_PTR 12'h014
`define RWI_OFF_INT_CTRL 12'h018
`define RWI_OFF_PERIPH_FLAG 12'h01C
`define RWI_OFF_PORT_PINS 12'h020
`define RWI_OFF_PORT_LATCH 12'h024
`define RWI_OFF_PORT_DIR 12'h028
`define RWI_OFF_CFG 12'h02C
// widths
`define RWI_PC_W 21
`define RWI_SP_W 5
// vectors
`define RWI_VEC_HIGH 21'h000008
`define RWI_VEC_LOW 21'h000018
`define RWI_PC_STEP 21'h000002
// interrupt control reset values, unimplemented masks
`define RWI_INTCON_RST 8'h00
`define RWI_INTCON2_RST 8'hF5
`define RWI_INTCON2_IMPL 8'hF5
`define RWI_INTCON3_RST 8'hC0
`define RWI_INTCON3_IMPL 8'hDB
`define RWI_PIR1_IMPL 8'h7F
`define RWI_PIR2_IMPL 8'h1F
`define RWI_PORT_BIT6 6
`define RWI_HIGH_PRIORITY_GLOBAL_ENABLE_BIT 7
`define RWI_LOW_PRIORITY_GLOBAL_ENABLE_BIT 6
// status bits: 0 por, 1 group reset, 2 wake, 3 vectored
`define RWI_EV_W 4
`define RWI_EV_POR 0
`define RWI_EV_GRP 1
`define RWI_EV_WAKE 2
`define RWI_EV_VEC 3
// ctrl bit: software reset request
`define RWI_CTRL_SWRST 0
`endif

// ### hw/rwi_pkg.sv
package rwi_pkg;
  typedef enum logic [1:0] {
    RWI_RST_NONE = 2'h0,
    RWI_RST_POR = 2'h1,
    RWI_RST_GRP = 2'h3,
    RWI_RST_WAKE = 2'h2
  } rwi_rst_class_t;
  typedef enum logic [1:0] {
    RWI_OSC_OTHER = 2'h0,
    RWI_OSC_EXT_IO = 2'h1,
    RWI_OSC_RC_IO = 2'h3
  } rwi_osc_mode_t;
  typedef enum logic [1:0] {
    RWI_ST_RUN = 2'h0,
    RWI_ST_SLEEP = 2'h1,
    RWI_ST_WAKE = 2'h3
  } rwi_state_t;
endpackage

// ### hw/rwi_port_gate.sv
`timescale 1ns/1ns
`include "rwi_defines.svh"
// masks bit 6 of the first port registers by variant and oscillator mode
module rwi_port_gate
  import rwi_pkg::*;
(
  // config
  input wire logic bit6_present,
  input wire rwi_osc_mode_t osc_mode,
  // raw values
  input wire logic [7:0] raw_pins,
  input wire logic [7:0] raw_latch,
  input wire logic [7:0] raw_dir,
  // gated values
  output logic [7:0] first_port_pins,
  output logic [7:0] first_port_latch,
  output logic [7:0] first_port_direction
);
  logic bit6_on;
  logic [7:0] keep;
  assign bit6_on = bit6_present &
                   ((osc_mode == RWI_OSC_EXT_IO) | (osc_mode == RWI_OSC_RC_IO));
  assign keep = ~(8'h01 << `RWI_PORT_BIT6) | ({8{bit6_on}} & (8'h01 << `RWI_PORT_BIT6));
  assign first_port_pins = raw_pins & keep;
  assign first_port_latch = raw_latch & keep;
  assign first_port_direction = raw_dir & keep;
endmodule // rwi_port_gate

// ### sim/rwi_checker_assertions.sv
`timescale 1ns/1ns
`include "rwi_defines.svh"
// cfg is not a port, so port checks lean on reset defaults
module rwi_checker (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  // events
  input wire logic POR_EVENT,
  input wire logic GRP_RESET_EVENT,
  input wire logic WAKE_IRQ,
  input wire logic WAKE_IRQ_HIGH,
  // outputs
  input wire logic [7:0] PORT_LATCH_OUT,
  input wire logic [7:0] PORT_DIR_OUT,
  input wire logic [`RWI_PC_W-1:0] PC_OUT,
  input wire logic ASLEEP,
  input wire logic IRQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  logic rd;
  // read access cycle: data was latched at setup
  assign rd = PSEL && PENABLE && !PWRITE;
  property p_int_zero;
    rd && PADDR == `RWI_OFF_INT_CTRL |-> (PRDATA & ~32'h00DBF5FF) == 32'h0;
  endproperty
  a_int_zero: assert property (p_int_zero) else $error("int ctrl spare bit");
  property p_pflag_zero;
    rd && PADDR == `RWI_OFF_PERIPH_FLAG |-> (PRDATA & ~32'h00001F7F) == 32'h0;
  endproperty
  a_pflag_zero: assert property (p_pflag_zero) else $error("pflag spare bit");
  property p_unmapped;
    rd && PADDR >= 12'h030 |-> PRDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
  property p_rst_vals;
    $fell(RST) |-> PC_OUT == 0 && PORT_LATCH_OUT == 8'h00 && PORT_DIR_OUT == 8'hBF && !IRQ;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad reset values");
  property p_por;
    POR_EVENT |=> PC_OUT == 0 && PORT_LATCH_OUT == 8'h00;
  endproperty
  a_por: assert property (p_por) else $error("power-on reset ignored");
  property p_grp;
    GRP_RESET_EVENT |=> PC_OUT == 0 && PORT_DIR_OUT[5:0] == 6'h3F;
  endproperty
  a_grp: assert property (p_grp) else $error("group reset ignored");
  property p_vec_hi;
    $fell(ASLEEP) && WAKE_IRQ && WAKE_IRQ_HIGH |-> PC_OUT != `RWI_VEC_LOW;
  endproperty
  a_vec_hi: assert property (p_vec_hi) else $error("low vector on high wake");
  property p_vec_lo;
    $fell(ASLEEP) && WAKE_IRQ && !WAKE_IRQ_HIGH |-> PC_OUT != `RWI_VEC_HIGH;
  endproperty
  a_vec_lo: assert property (p_vec_lo) else $error("high vector on low wake");
  property p_wake;
    ASLEEP && WAKE_IRQ |-> ##[1:3] !ASLEEP;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on interrupt");
endmodule // rwi_checker
bind rwi_reset_wake_init rwi_checker u_chk (.CORE_CLK, .RST, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PRDATA, .POR_EVENT, .GRP_RESET_EVENT, .WAKE_IRQ, .WAKE_IRQ_HIGH,
  .PORT_LATCH_OUT, .PORT_DIR_OUT, .PC_OUT, .ASLEEP, .IRQ);

// ### sim/test_reset_wake_register_init.sv
`timescale 1ns/1ns
`include "rwi_defines.svh"
`define CHK(a, e, s) begin checks++; if ((s) !== (e)) begin error_cnt++; \
  $display("wrong value at %h exp %h got %h", a, e, s); end end
module test_reset_wake_register_init;
  logic CORE_CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR;
  logic POR_EVENT = 0, GRP_RESET_EVENT = 0, SLEEP_REQ = 0, WAKE_WDT = 0, WAKE_IRQ = 0;
  logic WAKE_IRQ_HIGH = 0, ASLEEP, IRQ, exp_irq = 0, vec;
  logic [11:0] PADDR = 12'h000, ax;
  logic [31:0] PWDATA = 32'h0, PRDATA, r = 32'h6F1F;
  logic [7:0] WAKE_PERIPH_FLAGS = 8'h00, PORT_PIN_IN = 8'h00, PORT_LATCH_OUT, PORT_DIR_OUT;
  logic [7:0] m, f;
  logic [`RWI_PC_W-1:0] PC_OUT, pc, tos = 0;
  logic [4:0] sp = 0;
  logic [32:0] exq[$], ex;
  logic [11:0] adq[$];
  int error_cnt = 0, checks = 0, n;
  always #5 CORE_CLK = ~CORE_CLK;
  rwi_reset_wake_init dut (.CORE_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .POR_EVENT, .GRP_RESET_EVENT, .SLEEP_REQ, .WAKE_WDT,
    .WAKE_IRQ, .WAKE_PERIPH_FLAGS, .WAKE_IRQ_HIGH, .PORT_PIN_IN, .PORT_LATCH_OUT,
    .PORT_DIR_OUT, .PC_OUT, .ASLEEP, .IRQ);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task end_of_test;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one apb transfer; the wait for pready is bounded
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'h1;
    n = 0;
    do begin @(posedge CORE_CLK); n++; end while (PREADY !== 1'h1 && n < 20);
    if (n >= 20) begin error_cnt++; end_of_test; end
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    exq.push_back({exp_irq, e});
    adq.push_back(a);
    apb(1'h0, a, 32'h0);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  // sampled at negedge so the level has settled
  task wait_asleep(input logic v);
    for (n = 0; n < 20 && ASLEEP !== v; n++) @(negedge CORE_CLK);
    if (n >= 20) begin error_cnt++; end_of_test; end
  endtask
  // irq rides along with the read data, oldest note first
  always @(posedge CORE_CLK) begin
    if (PSEL && PENABLE && PREADY && !PWRITE) begin
      ex = exq.pop_front();
      ax = adq.pop_front();
      `CHK(ax, ex, {IRQ, PRDATA})
      `CHK(ax, 1'h0, PSLVERR)
    end
  end
  initial begin
    repeat (3) @(posedge CORE_CLK);
    RST <= 1'h0;
    rd(`RWI_OFF_INT_CTRL, 32'h00C0F500);
    rd(`RWI_OFF_PORT_DIR, 32'h000000BF);
    rd(12'h030, 32'h0);
    wr(`RWI_OFF_INT_CTRL, 32'hFFFFFFFF);
    wr(`RWI_OFF_PERIPH_FLAG, 32'hFFFFFFFF);
    rd(`RWI_OFF_INT_CTRL, 32'h00DBF5FF);
    rd(`RWI_OFF_PERIPH_FLAG, 32'h00001F7F);
    // every presence and oscillator setting against bit 6
    for (int i = 0; i < 8; i++) begin
      r = lfsr(r);
      PORT_PIN_IN <= r[7:0];
      wr(`RWI_OFF_CFG, 32'(i));
      wr(`RWI_OFF_PORT_LATCH, 32'hFF);
      m = (i[0] && i[1]) ? 8'hFF : 8'hBF;
      rd(`RWI_OFF_PORT_LATCH, {24'h0, m});
      rd(`RWI_OFF_PORT_PINS, {24'h0, r[7:0] & m});
    end
    // wakes: high irq, low irq, irq without enable, watchdog
    wr(`RWI_OFF_MASK, 32'h8);
    for (int k = 0; k < 4; k++) begin
      r = lfsr(r);
      pc = {r[20:1], 1'h0};
      f = k < 3 ? (r[31:24] | 8'h01) : 8'h00;
      vec = k < 2;
      wr(`RWI_OFF_PC, {11'h0, pc});
      wr(`RWI_OFF_INT_CTRL, k == 0 ? 32'h80 : (k == 1 ? 32'h40 : 32'h0));
      wr(`RWI_OFF_PERIPH_FLAG, 32'h0);
      wr(`RWI_OFF_STATUS, 32'hF);
      SLEEP_REQ <= 1'h1;
      @(posedge CORE_CLK);
      SLEEP_REQ <= 1'h0;
      wait_asleep(1'h1);
      @(posedge CORE_CLK);
      WAKE_IRQ <= k < 3;
      WAKE_WDT <= k == 3;
      WAKE_IRQ_HIGH <= k == 0;
      WAKE_PERIPH_FLAGS <= f;
      wait_asleep(1'h0);
      @(posedge CORE_CLK);
      WAKE_IRQ <= 1'h0;
      WAKE_WDT <= 1'h0;
      if (vec) begin tos = pc; sp++; end
      exp_irq = vec;
      rd(`RWI_OFF_PC, vec ? (k == 0 ? 32'h8 : 32'h18) : {11'h0, pc + 21'h2});
      rd(`RWI_OFF_STACK_TOP, {11'h0, tos});
      rd(`RWI_OFF_STACK_PTR, {27'h0, sp});
      rd(`RWI_OFF_PERIPH_FLAG, {24'h0, f & 8'h7F});
      rd(`RWI_OFF_STATUS, vec ? 32'hC : 32'h4);
      wr(`RWI_OFF_STATUS, 32'hF);
      exp_irq = 1'h0;
    end
    // software, group pin and power-on resets
    for (int j = 0; j < 3; j++) begin
      wr(`RWI_OFF_PC, 32'h100);
      wr(`RWI_OFF_INT_CTRL, 32'hFF);
      wr(`RWI_OFF_STATUS, 32'hF);
      if (j == 0) wr(`RWI_OFF_CTRL, 32'h1);
      else begin
        @(posedge CORE_CLK);
        POR_EVENT <= j == 2;
        GRP_RESET_EVENT <= j == 1;
        @(posedge CORE_CLK);
        POR_EVENT <= 1'h0;
        GRP_RESET_EVENT <= 1'h0;
      end
      if (j == 2) sp = 0;
      rd(`RWI_OFF_PC, 32'h0);
      rd(`RWI_OFF_INT_CTRL, 32'h00C0F500);
      rd(`RWI_OFF_STACK_PTR, {27'h0, sp});
      rd(`RWI_OFF_STATUS, j == 2 ? 32'h1 : 32'h2);
    end
    end_of_test;
  end
endmodule // test_reset_wake_register_init
